//--- pkg/apc_pkg.sv
// Function
// - Proportional type maps demand 0-100% linearly between zero and full demand currents.
// - Without feedback the proportional type runs open loop and keeps trim off.
// - With trim_on false the proportional output equals the untrimmed linear demand map.
// - With trim on an integrator drives demand minus feedback toward zero.
// - Trim integrator is clamped to plus or minus a tenth of the current span.
// - Proportional trimming uses a first-order lag on the demand.
// - Integrating types raise or lower current to cancel demand minus feedback.
// - Forward P type with zero error outputs exactly the null current.
// - Forward demand above feedback drives current above null, below drives it below.
// - Type codes are 1 proportional, 2 P, 3 PI, 4 Pi_with_lag_type, 5 PI lead/lag.
// - P type outputs null current plus proportional gain times error.
// - PI type adds proportional term and integral of error to the null current.
// - PI-with-lag type lags the demand before forming the error.
// - Lead/lag type uses configured lead time and lag derived from the ratio.
// - Trim setting is honoured only in the proportional type.
// - Forward gives rising current for rising demand, reverse gives falling current.
// - Feedback type selects none, A, A minus B, or (A-B)/(A+B).
// - Open-circuit alarms are flagged only while the alarm option is enabled.
// - Integral gain is used only by trimmed proportional and the PI types.
// - Lag applies to trimmed proportional, Pi_with_lag_type and lead/lag types, lead only to lead/lag.
package apc_pkg;

	typedef enum logic [2:0] {
		APC_TYPE_PROPORTIONAL_TYPE = 3'h1,
		APC_TYPE_P = 3'h2,
		APC_TYPE_PI = 3'h3,
		APC_TYPE_PI_WITH_LAG_TYPE = 3'h4,
		APC_TYPE_PI_LEAD_LAG = 3'h5
	} apc_type_e;

	typedef enum logic [1:0] {
		APC_FB_NONE = 2'h0,
		APC_FB_A = 2'h1,
		APC_FB_DIFF = 2'h2,
		APC_FB_RATIO = 2'h3
	} apc_fb_e;

	typedef struct packed {
		logic clear_states;
		logic trim_on;
		logic open_alarm_en;
		apc_fb_e fb_type;
		logic reverse;
		apc_type_e ctrl_type;
	} apc_ctrl_s;

	typedef struct packed {
		logic saturated;
		logic fb_fail;
		logic fb_open;
	} apc_status_s;

	localparam logic [7:0] APC_OFS_CTRL = 8'h00;
	localparam logic [7:0] APC_OFS_DEMAND = 8'h04;
	localparam logic [7:0] APC_OFS_ZERO = 8'h08;
	localparam logic [7:0] APC_OFS_FULL = 8'h0C;
	localparam logic [7:0] APC_OFS_NULL = 8'h10;
	localparam logic [7:0] APC_OFS_MIN = 8'h14;
	localparam logic [7:0] APC_OFS_MAX = 8'h18;
	localparam logic [7:0] APC_OFS_KP = 8'h1C;
	localparam logic [7:0] APC_OFS_KI = 8'h20;
	localparam logic [7:0] APC_OFS_LAG = 8'h24;
	localparam logic [7:0] APC_OFS_LEAD = 8'h28;
	localparam logic [7:0] APC_OFS_RATIO = 8'h2C;
	localparam logic [7:0] APC_OFS_STATUS = 8'h30;
	localparam logic [7:0] APC_OFS_CURRENT = 8'h34;
	localparam logic [7:0] APC_OFS_FEEDBACK = 8'h38;

	localparam apc_ctrl_s APC_CTRL_RST = '{clear_states: 1'b0, trim_on: 1'b0, open_alarm_en: 1'b1,
		fb_type: APC_FB_NONE, reverse: 1'b0, ctrl_type: APC_TYPE_PROPORTIONAL_TYPE};
	localparam logic [15:0] APC_FULL_SCALE = 16'h8000;
	localparam logic [15:0] APC_ZERO_RST = 16'h0FA0;
	localparam logic [15:0] APC_FULL_RST = 16'h4E20;
	localparam logic [15:0] APC_NULL_RST = 16'h2710;
	localparam logic [15:0] APC_MIN_RST = 16'h0000;
	localparam logic [15:0] APC_MAX_RST = 16'h4E20;
	localparam logic [15:0] APC_KP_RST = 16'h0100;
	localparam logic [15:0] APC_KI_RST = 16'h0000;
	localparam logic [15:0] APC_LAG_RST = 16'h0001;
	localparam logic [15:0] APC_LEAD_RST = 16'h0001;
	localparam logic [15:0] APC_RATIO_RST = 16'h0100;
	localparam int APC_KP_SHIFT = 8;
	localparam int APC_KI_SHIFT = 16;
	localparam int APC_FILT_FRAC = 8;
	localparam int APC_RATIO_FRAC = 8;
	localparam int APC_CLK_MHZ = 100;
	localparam int APC_SAMPLE_US = 100;
	localparam int APC_SAMPLE_CYCLES = APC_SAMPLE_US * APC_CLK_MHZ;
	localparam logic [7:0] APC_FAIL_SAMPLES = 8'h0A;

endpackage

//--- verif/apc_core_checker.sv
module apc_core_checker import apc_pkg::*; #(
	parameter int SAMPLE_CYCLES = 16
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic signed [15:0] current_cmd,
	input wire logic sample_tick,
	input wire apc_pkg::apc_status_s alarms
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	logic acc;
	logic wst;
	logic seen_r;
	logic [15:0] gap_r;
	assign acc = psel && penable;
	assign wst = acc && pwrite && paddr == 32'h30;
	// Counts cycles since the last sample pulse.
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap_r <= 16'h0;
			seen_r <= 1'b0;
		end else if (sample_tick) begin
			gap_r <= 16'h1;
			seen_r <= 1'b1;
		end else begin
			gap_r <= gap_r + 16'h1;
		end
	end
	sequence pulse_s;
		sample_tick ##1 !sample_tick;
	endsequence
	////////////////////////////////////////////////////////////////////////
	ready_high_a: assert property (pready) else $error("pready low");
	err_in_access_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
	unmapped_err_a: assert property (acc && paddr[31:8] != 24'h0 |-> pslverr) else $error("no pslverr");
	mapped_ok_a: assert property (acc && paddr[31:8] == 24'h0 && paddr[1:0] == 2'h0 && paddr[7:0] <= 8'h38
		|-> !pslverr) else $error("pslverr on mapped word");
	tick_pulse_a: assert property (sample_tick |-> pulse_s) else $error("tick too long");
	tick_period_a: assert property (seen_r && (sample_tick || gap_r >= 16'(SAMPLE_CYCLES))
		|-> sample_tick && gap_r == 16'(SAMPLE_CYCLES)) else $error("tick period wrong");
	cmd_hold_a: assert property (!sample_tick |=> $stable(current_cmd) || current_cmd == 16'sh0)
		else $error("current changed off tick");
	fail_after_open_a: assert property ($rose(alarms.fb_fail) |-> alarms.fb_open)
		else $error("fail without open");
	sticky_clear_a: assert property ($fell(alarms.fb_open) || $fell(alarms.fb_fail) || $fell(alarms.saturated)
		|-> $past(wst) || $past(wst, 2)) else $error("alarm cleared without write");
	sat_on_tick_a: assert property ($rose(alarms.saturated) |-> $past(sample_tick) || $past(sample_tick, 2))
		else $error("saturation off tick");
endmodule // apc_core_checker

bind apc_core apc_core_checker #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) chk (.core_clk(core_clk), .arst_n(arst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.current_cmd(current_cmd), .sample_tick(sample_tick), .alarms(alarms));

//--- verif/apc_core_test.sv
module apc_core_test import apc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rv;
	logic pready, pslverr, sample_tick, ev, fo_a, fo_b;
	logic open_a = 1'b0;
	logic open_b = 1'b0;
	logic [15:0] pos_a = 16'h0;
	logic [15:0] pos_b = 16'h0;
	logic [15:0] fa, fb;
	logic signed [15:0] current_cmd, c1;
	apc_status_s alarms;
	int n_errors = 0;
	int n_checks = 0;
	logic [15:0] rst_v [10] = '{16'h0FA0, 16'h4E20, 16'h2710, 16'h0000, 16'h4E20, 16'h0100, 16'h0000,
		16'h0001, 16'h0001, 16'h0100};
	// Each entry: control, demand, channel A, channel B, expected current.
	logic [79:0] tv [18] = '{80'h0041_0000_0000_0000_0FA0, 80'h0041_8000_0000_0000_4E20,
		80'h0041_4000_0000_0000_2EE0, 80'h0041_2000_0000_0000_1F40, 80'h0049_0000_0000_0000_4E20,
		80'h0049_2000_0000_0000_3E80, 80'h00C1_4000_0000_0000_2EE0, 80'h0051_4000_0000_0000_2EE0,
		80'h00D1_4000_0000_0000_3520, 80'h0052_4000_4000_0000_2710, 80'h0052_4000_3000_0000_3710,
		80'h0052_3000_4000_0000_1710, 80'h005A_4000_3000_0000_1710, 80'h00D2_4000_3000_0000_3710,
		80'h0062_4000_5000_1000_2710, 80'h0072_4000_3000_1000_2710, 80'h0052_0000_8000_0000_0000,
		80'h0052_8000_0000_0000_4E20};
	always #5 core_clk = ~core_clk;
	apc_core #(.SAMPLE_CYCLES(16)) dut (.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fb_a_pin(fa), .fb_b_pin(fb), .fb_open_a_pin(fo_a), .fb_open_b_pin(fo_b), .current_cmd(current_cmd),
		.sample_tick(sample_tick), .alarms(alarms));
	apc_fb_model fbm (.core_clk(core_clk), .pos_a(pos_a), .pos_b(pos_b), .open_a(open_a), .open_b(open_b),
		.fb_a_pin(fa), .fb_b_pin(fb), .fb_open_a_pin(fo_a), .fb_open_b_pin(fo_b));
	////////////////////////////////////////////////////////////////////////
	task finish_test;
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
		int i;
		i = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_errors++;
			finish_test();
		end
	endtask
	task ticks(input int n);
		int i;
		repeat (n) begin
			i = 0;
			do begin
				@(negedge core_clk);
				i++;
			end while (sample_tick !== 1'b1 && i < 40);
			if (i >= 40) begin
				n_errors++;
				finish_test();
			end
		end
		@(negedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge core_clk);
		arst_n <= 1'b1;
		apb(1'b0, APC_OFS_CTRL, 32'h0);
		chk(rv, 32'h41);
		for (int k = 0; k < 10; k++) begin
			apb(1'b0, 32'h8 + 4 * k, 32'h0);
			chk(rv, {16'h0, rst_v[k]});
		end
		apb(1'b0, 32'h3C, 32'h0);
		chk(ev, 32'h1);
		apb(1'b1, 32'h100, 32'h0);
		chk(ev, 32'h1);
		apb(1'b1, APC_OFS_KI, 32'hFFFF);
		foreach (tv[k]) begin
			apb(1'b1, APC_OFS_CTRL, {16'h0, tv[k][79:64]});
			pos_a <= tv[k][47:32];
			pos_b <= tv[k][31:16];
			apb(1'b1, APC_OFS_DEMAND, {16'h0, tv[k][63:48]});
			ticks(3);
			chk(current_cmd, {16'h0, tv[k][15:0]});
		end
		chk(alarms.saturated, 32'h1);
		apb(1'b1, APC_OFS_KP, 32'h0);
		apb(1'b1, APC_OFS_KI, 32'h1000);
		pos_a <= 16'h3000;
		apb(1'b1, APC_OFS_DEMAND, 32'h4000);
		for (int t = 3; t < 6; t++) begin
			apb(1'b1, APC_OFS_CTRL, 32'h150 + t);
			ticks(1);
			chk(current_cmd, 32'h0);
			apb(1'b1, APC_OFS_CTRL, 32'h50 + t);
			ticks(3);
			c1 = current_cmd;
			ticks(1);
			chk(current_cmd - c1, 32'h100);
		end
		apb(1'b1, APC_OFS_STATUS, 32'h7);
		apb(1'b1, APC_OFS_CTRL, 32'h52);
		open_a <= 1'b1;
		ticks(14);
		chk(alarms.fb_open, 32'h1);
		chk(alarms.fb_fail, 32'h1);
		apb(1'b0, APC_OFS_STATUS, 32'h0);
		chk(rv, 32'h3);
		apb(1'b0, APC_OFS_CURRENT, 32'h0);
		chk(rv, 32'h2710);
		apb(1'b1, APC_OFS_CTRL, 32'h12);
		apb(1'b1, APC_OFS_STATUS, 32'h7);
		ticks(14);
		chk({alarms.fb_fail, alarms.fb_open}, 32'h0);
		finish_test();
	end
endmodule // apc_core_test

//--- verif/apc_fb_model.sv
module apc_fb_model (
	input wire logic core_clk,
	input wire logic [15:0] pos_a,
	input wire logic [15:0] pos_b,
	input wire logic open_a,
	input wire logic open_b,
	output logic [15:0] fb_a_pin,
	output logic [15:0] fb_b_pin,
	output logic fb_open_a_pin,
	output logic fb_open_b_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] wob_r = 16'h0;
	// A broken wire no longer holds its last value, so it shows a moving pattern.
	always_ff @(posedge core_clk) begin
		wob_r <= wob_r + 16'h03A7;
		fb_a_pin <= open_a ? wob_r : pos_a;
		fb_b_pin <= open_b ? ~wob_r : pos_b;
		fb_open_a_pin <= open_a;
		fb_open_b_pin <= open_b;
	end
endmodule // apc_fb_model

//--- verilog/apc_core.sv
module apc_core #(
	parameter int SAMPLE_CYCLES = apc_pkg::APC_SAMPLE_CYCLES
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] fb_a_pin,
	input wire logic [15:0] fb_b_pin,
	input wire logic fb_open_a_pin,
	input wire logic fb_open_b_pin,
	output logic signed [15:0] current_cmd,
	output logic sample_tick,
	output apc_pkg::apc_status_s alarms
);
	import apc_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Registers and synchronisers.

	apc_ctrl_s ctrl_r;
	logic [15:0] demand_r;
	logic [15:0] zero_r;
	logic [15:0] full_r;
	logic [15:0] null_r;
	logic [15:0] min_r;
	logic [15:0] max_r;
	logic [15:0] kp_r;
	logic [15:0] ki_r;
	logic [15:0] lag_r;
	logic [15:0] lead_r;
	logic [15:0] ratio_r;
	apc_status_s status_r;
	logic [31:0] prdata_r;
	logic [15:0] fb_a_s1_r;
	logic [15:0] fb_a_s2_r;
	logic [15:0] fb_b_s1_r;
	logic [15:0] fb_b_s2_r;
	logic [1:0] open_s1_r;
	logic [1:0] open_s2_r;
	logic [31:0] div_cnt_r;
	logic sample_r;
	logic signed [31:0] filt_r;
	logic signed [31:0] tint_r;
	logic signed [31:0] iint_r;
	logic signed [31:0] fb_pos_r;
	logic signed [15:0] current_r;
	logic [7:0] open_cnt_r;

	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic [7:0] ofs;

	assign ofs = paddr[7:0];
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable;
	assign addr_ok = (paddr[31:8] == 24'h000000) && (ofs <= APC_OFS_FEEDBACK) && (ofs[1:0] == 2'h0);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~addr_ok;
	assign prdata = prdata_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			fb_a_s1_r <= 16'h0000;
			fb_a_s2_r <= 16'h0000;
			fb_b_s1_r <= 16'h0000;
			fb_b_s2_r <= 16'h0000;
			open_s1_r <= 2'h0;
			open_s2_r <= 2'h0;
		end else begin
			fb_a_s1_r <= fb_a_pin;
			fb_a_s2_r <= fb_a_s1_r;
			fb_b_s1_r <= fb_b_pin;
			fb_b_s2_r <= fb_b_s1_r;
			open_s1_r <= {fb_open_b_pin, fb_open_a_pin};
			open_s2_r <= open_s1_r;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			div_cnt_r <= 32'h00000000;
			sample_r <= 1'b0;
		end else if (div_cnt_r >= 32'(SAMPLE_CYCLES - 1)) begin
			div_cnt_r <= 32'h00000000;
			sample_r <= 1'b1;
		end else begin
			div_cnt_r <= div_cnt_r + 32'h00000001;
			sample_r <= 1'b0;
		end
	end
	assign sample_tick = sample_r;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r <= APC_CTRL_RST;
			demand_r <= 16'h0000;
			zero_r <= APC_ZERO_RST;
			full_r <= APC_FULL_RST;
			null_r <= APC_NULL_RST;
			min_r <= APC_MIN_RST;
			max_r <= APC_MAX_RST;
			kp_r <= APC_KP_RST;
			ki_r <= APC_KI_RST;
			lag_r <= APC_LAG_RST;
			lead_r <= APC_LEAD_RST;
			ratio_r <= APC_RATIO_RST;
		end else if (wr_en && addr_ok) begin
			if (ofs == APC_OFS_CTRL) begin
				ctrl_r <= apc_ctrl_s'(pwdata[8:0]);
			end else if (ofs == APC_OFS_DEMAND) begin
				demand_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_ZERO) begin
				zero_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_FULL) begin
				full_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_NULL) begin
				null_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_MIN) begin
				min_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_MAX) begin
				max_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_KP) begin
				kp_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_KI) begin
				ki_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_LAG) begin
				lag_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_LEAD) begin
				lead_r <= pwdata[15:0];
			end else if (ofs == APC_OFS_RATIO) begin
				ratio_r <= pwdata[15:0];
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata_r <= 32'h00000000;
		end else if (rd_setup) begin
			if (!addr_ok) begin
				prdata_r <= 32'h00000000;
			end else if (ofs == APC_OFS_CTRL) begin
				prdata_r <= {23'h000000, ctrl_r};
			end else if (ofs == APC_OFS_DEMAND) begin
				prdata_r <= {16'h0000, demand_r};
			end else if (ofs == APC_OFS_ZERO) begin
				prdata_r <= {16'h0000, zero_r};
			end else if (ofs == APC_OFS_FULL) begin
				prdata_r <= {16'h0000, full_r};
			end else if (ofs == APC_OFS_NULL) begin
				prdata_r <= {16'h0000, null_r};
			end else if (ofs == APC_OFS_MIN) begin
				prdata_r <= {16'h0000, min_r};
			end else if (ofs == APC_OFS_MAX) begin
				prdata_r <= {16'h0000, max_r};
			end else if (ofs == APC_OFS_KP) begin
				prdata_r <= {16'h0000, kp_r};
			end else if (ofs == APC_OFS_KI) begin
				prdata_r <= {16'h0000, ki_r};
			end else if (ofs == APC_OFS_LAG) begin
				prdata_r <= {16'h0000, lag_r};
			end else if (ofs == APC_OFS_LEAD) begin
				prdata_r <= {16'h0000, lead_r};
			end else if (ofs == APC_OFS_RATIO) begin
				prdata_r <= {16'h0000, ratio_r};
			end else if (ofs == APC_OFS_STATUS) begin
				prdata_r <= {29'h00000000, status_r};
			end else if (ofs == APC_OFS_CURRENT) begin
				prdata_r <= {16'h0000, current_r};
			end else begin
				prdata_r <= fb_pos_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Feedback interpretation and demand conditioning.

	logic signed [31:0] fb_a, fb_b, fb_sum, fb_pos_nxt, dem, lag_out, ll_out, dem_cond;
	logic signed [31:0] filt_nxt, lag_samp;
	logic signed [47:0] filt_step, ll_step;
	logic signed [47:0] ratio_num;
	logic [15:0] alpha;
	logic is_pi, fb_used, trim_act;

	assign fb_a = $signed({16'h0000, fb_a_s2_r});
	assign fb_b = $signed({16'h0000, fb_b_s2_r});
	assign fb_sum = fb_a + fb_b;
	assign fb_used = (ctrl_r.fb_type != APC_FB_NONE);
	assign ratio_num = 48'(fb_a - fb_b) <<< 15;

	always_comb begin
		fb_pos_nxt = 32'sh00000000;
		if (ctrl_r.fb_type == APC_FB_A) begin
			fb_pos_nxt = fb_a;
		end else if (ctrl_r.fb_type == APC_FB_DIFF) begin
			fb_pos_nxt = fb_a - fb_b;
		end else if (ctrl_r.fb_type == APC_FB_RATIO && fb_sum != 32'sh00000000) begin
			fb_pos_nxt = 32'(ratio_num / 48'(fb_sum));
		end
	end

	assign dem = (demand_r > APC_FULL_SCALE) ? $signed({16'h0000, APC_FULL_SCALE}) : $signed({16'h0000, demand_r});

	// Lag time is taken directly, or for lead/lag derived from lead time over ratio.
	always_comb begin
		lag_samp = $signed({16'h0000, lag_r});
		if (ctrl_r.ctrl_type == APC_TYPE_PI_LEAD_LAG && ratio_r != 16'h0000) begin
			lag_samp = ($signed({16'h0000, lead_r}) <<< APC_RATIO_FRAC) / $signed({16'h0000, ratio_r});
		end
		if (lag_samp < 32'sh00000001) begin
			lag_samp = 32'sh00000001;
		end
		if (lag_samp > 32'sh00008000) begin
			lag_samp = 32'sh00008000;
		end
	end
	assign alpha = 16'(32'sh00008000 / lag_samp);

	assign filt_step = 48'((dem <<< APC_FILT_FRAC) - filt_r) * $signed({32'h00000000, alpha});
	assign filt_nxt = filt_r + 32'(filt_step >>> 15);
	assign lag_out = filt_r >>> APC_FILT_FRAC;
	assign ll_step = 48'(dem - lag_out) * $signed({32'h00000000, ratio_r});
	assign ll_out = lag_out + 32'(ll_step >>> APC_RATIO_FRAC);

	always_comb begin
		dem_cond = dem;
		if (ctrl_r.ctrl_type == APC_TYPE_PI_WITH_LAG_TYPE) begin
			dem_cond = lag_out;
		end else if (ctrl_r.ctrl_type == APC_TYPE_PI_LEAD_LAG) begin
			dem_cond = ll_out;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Proportional type with command trim.

	logic signed [31:0] span, span_abs, trim_lim, base, terr, tint_nxt, proportional_type_out;
	logic signed [47:0] base_prod, tint_prod;

	assign span = $signed({16'h0000, full_r}) - $signed({16'h0000, zero_r});
	assign span_abs = (span < 32'sh00000000) ? -span : span;
	assign trim_lim = span_abs / 32'sh0000000A;
	assign base_prod = 48'(span) * 48'(ctrl_r.reverse ? $signed({16'h0000, APC_FULL_SCALE}) - dem : dem);
	assign base = $signed({16'h0000, zero_r}) + 32'(base_prod >>> 15);
	assign trim_act = (ctrl_r.ctrl_type == APC_TYPE_PROPORTIONAL_TYPE) && ctrl_r.trim_on && fb_used;
	assign terr = lag_out - fb_pos_r;
	assign tint_prod = 48'(terr) * $signed({32'h00000000, ki_r});

	always_comb begin
		tint_nxt = tint_r + 32'(tint_prod >>> APC_KI_SHIFT);
		if (tint_nxt > trim_lim) begin
			tint_nxt = trim_lim;
		end else if (tint_nxt < -trim_lim) begin
			tint_nxt = -trim_lim;
		end
		proportional_type_out = base;
		if (trim_act) begin
			proportional_type_out = ctrl_r.reverse ? base - tint_r : base + tint_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Integrating types.

	logic signed [31:0] err, pterm, raw, int_out, iint_nxt;
	logic signed [47:0] p_prod, i_prod;
	logic sat;

	assign is_pi = (ctrl_r.ctrl_type == APC_TYPE_PI) || (ctrl_r.ctrl_type == APC_TYPE_PI_WITH_LAG_TYPE) ||
		(ctrl_r.ctrl_type == APC_TYPE_PI_LEAD_LAG);
	assign err = ctrl_r.reverse ? fb_pos_r - dem_cond : dem_cond - fb_pos_r;
	assign p_prod = 48'(err) * $signed({32'h00000000, kp_r});
	assign pterm = 32'(p_prod >>> APC_KP_SHIFT);
	assign i_prod = 48'(err) * $signed({32'h00000000, ki_r});
	assign iint_nxt = iint_r + 32'(i_prod >>> APC_KI_SHIFT);
	assign raw = $signed({16'h0000, null_r}) + pterm + (is_pi ? iint_r : 32'sh00000000);

	always_comb begin
		int_out = raw;
		sat = 1'b0;
		if (raw > $signed({16'h0000, max_r})) begin
			int_out = $signed({16'h0000, max_r});
			sat = 1'b1;
		end else if (raw < $signed({16'h0000, min_r})) begin
			int_out = $signed({16'h0000, min_r});
			sat = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample-rate state.

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			filt_r <= 32'sh00000000;
			tint_r <= 32'sh00000000;
			iint_r <= 32'sh00000000;
			fb_pos_r <= 32'sh00000000;
		end else if (ctrl_r.clear_states) begin
			filt_r <= 32'sh00000000;
			tint_r <= 32'sh00000000;
			iint_r <= 32'sh00000000;
			fb_pos_r <= 32'sh00000000;
		end else if (sample_r) begin
			filt_r <= filt_nxt;
			fb_pos_r <= fb_pos_nxt;
			tint_r <= trim_act ? tint_nxt : 32'sh00000000;
			if (!is_pi) begin
				iint_r <= 32'sh00000000;
			end else if (!sat) begin
				iint_r <= iint_nxt;
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			current_r <= 16'sh0000;
		end else if (ctrl_r.clear_states) begin
			current_r <= 16'sh0000;
		end else if (sample_r) begin
			current_r <= (ctrl_r.ctrl_type == APC_TYPE_PROPORTIONAL_TYPE) ? proportional_type_out[15:0] : int_out[15:0];
		end
	end
	assign current_cmd = current_r;

	////////////////////////////////////////////////////////////////////////////////
	// Open-circuit and saturation alarms, sticky until written with one; a new event wins.

	logic open_now, fail_now;

	assign open_now = ctrl_r.open_alarm_en && fb_used &&
		(open_s2_r[0] || (ctrl_r.fb_type != APC_FB_A && open_s2_r[1]));
	assign fail_now = open_now && (open_cnt_r >= APC_FAIL_SAMPLES);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			open_cnt_r <= 8'h00;
		end else if (!open_now) begin
			open_cnt_r <= 8'h00;
		end else if (sample_r && open_cnt_r < APC_FAIL_SAMPLES) begin
			open_cnt_r <= open_cnt_r + 8'h01;
		end
	end

	logic status_wr;
	logic [2:0] flag_set;
	logic [2:0] flag_nxt;

	assign status_wr = wr_en && addr_ok && (ofs == APC_OFS_STATUS);
	assign flag_set[0] = open_now;
	assign flag_set[1] = fail_now;
	assign flag_set[2] = sample_r && (ctrl_r.ctrl_type != APC_TYPE_PROPORTIONAL_TYPE) && sat;

	for (genvar g = 0; g < 3; g++) begin : g_flag
		assign flag_nxt[g] = flag_set[g] | (status_r[g] & ~(status_wr & pwdata[g]));
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_r <= '0;
		end else begin
			status_r <= apc_status_s'(flag_nxt);
		end
	end
	assign alarms = status_r;

endmodule // apc_core
